// File: hw/srps_defines.svh
`ifndef SRPS_DEFINES_SVH
`define SRPS_DEFINES_SVH

// Register byte offsets
`define SRPS_OFF_MODE 8'h00
`define SRPS_OFF_ENTRY_SEL 8'h04
`define SRPS_OFF_FRAME_CNT 8'h08
`define SRPS_OFF_NEXT_IDX 8'h0C
`define SRPS_OFF_OFFSET_Y 8'h10
`define SRPS_OFF_H_BIN 8'h14
`define SRPS_OFF_V_BIN 8'h18
`define SRPS_OFF_EXPOSURE 8'h1C
`define SRPS_OFF_GAIN 8'h20
`define SRPS_OFF_GAIN_RED 8'h24
`define SRPS_OFF_GAIN_BLUE 8'h28
`define SRPS_OFF_BLACK 8'h2C
`define SRPS_OFF_LUT_EN 8'h30
`define SRPS_OFF_LUT_MODE 8'h34
`define SRPS_OFF_CMD_IDX 8'h38
`define SRPS_OFF_CUR_IDX 8'h3C
`define SRPS_OFF_IDX_RESET 8'h40
`define SRPS_OFF_MROI_SEL 8'h44
`define SRPS_OFF_MROI_WIDTH 8'h48
`define SRPS_OFF_MROI_HEIGHT 8'h4C
`define SRPS_OFF_MROI_OFFX 8'h50
`define SRPS_OFF_MROI_OFFY 8'h54
`define SRPS_OFF_H_EN 8'h58
`define SRPS_OFF_V_EN 8'h5C

// Accepted ranges, as 32-bit signed bounds
`define SRPS_IDX_MIN 32'h0000_0001
`define SRPS_IDX_MAX 32'h0000_0080
`define SRPS_FCNT_MAX 32'h0000_00FF
`define SRPS_OFFY_MAX 32'h0000_04BE
`define SRPS_ZERO 32'h0000_0000
`define SRPS_BIN_MAX 32'h0000_0002
`define SRPS_EXP_MAX 32'h007A_1200
`define SRPS_GAIN_MIN 32'h0000_0064
`define SRPS_GAIN_MAX 32'h0000_0640
`define SRPS_CGAIN_MIN 32'hFFFF_EE4B
`define SRPS_CGAIN_MAX 32'h0000_93F4
`define SRPS_BLACK_MIN 32'hFFFF_FF7B
`define SRPS_BLACK_MAX 32'h0000_00FF
`define SRPS_MROI_MAX 32'h0000_0004
`define SRPS_WIDTH_MIN 32'h0000_0060
`define SRPS_WIDTH_MAX 32'h0000_0790
`define SRPS_HEIGHT_MIN 32'h0000_0002
`define SRPS_HEIGHT_MAX 32'h0000_04C0
`define SRPS_OFFX_MAX 32'h0000_0730

// Reset values at field width
`define SRPS_EXP_RST 23'h00_1F40
`define SRPS_GAIN_RST 11'h064
`define SRPS_CGAIN_RST 17'h0_93F4
`define SRPS_WIDTH_RST 11'h790
`define SRPS_HEIGHT_RST 11'h4C0
`define SRPS_FCNT_RST 8'h01

`endif

// File: hw/srps_pkg.sv
`default_nettype none
package srps_pkg;
   // Output mode selector values
   typedef enum logic [1:0] {SRPS_NORMAL, SRPS_FRAME_COUNT, SRPS_HOST_SEL} srps_mode_t;
   // Tone mapping selector values
   typedef enum logic {SRPS_GAMMA, SRPS_TABLE} srps_lut_t;
endpackage : srps_pkg
`default_nettype wire

// File: hw/srps_store.sv
// The Avalon-MM register port and the register addresses are this design's own decisions.
`include "srps_defines.svh"
`default_nettype none

// Contract
// - Every entry keeps a vertical offset 0..1214, reset 0.
// - Every entry keeps exposure up to 8000000, reset 8000, minimum set by tap layout.
// - Every entry keeps gain 100..1600, reset 100.
// - Every entry keeps signed red and blue gains -4533..37876, reset 37876.
// - Every entry keeps signed black level -133..255, reset 0.
// - Every entry keeps horizontal and vertical binning 1 or 2, reset 1, mono only.
// - Every entry keeps a tone mapping enable flag, reset false.
// - One tone mapping mode, gamma or table, reset gamma, used only for enabled entries.
// - Host-selected mode uses the entry number 1..128 the host commanded.
// - A read-only value shows the entry number of the image being output.
// - Index reset returns the current entry to 1 in both sequencing modes.
// - Multi-region table selector takes 1..4, reset 1.
// - Multi-region width 96..1936 reset 1936, height 2..1216 reset 1216.
// - Multi-region offsets: horizontal 0..1840, vertical 0..1214, both reset 0.
// - Horizontal enable, reset off, lets width and horizontal offset take effect.
// - Vertical enable, reset off, lets height and vertical offset take effect.
// - Output mode picks normal, frame-count or host-selected sequencing, reset normal.
// - Entry selector for per-entry settings takes 1..128, reset 1.
// - Frame-count mode uses each entry for its frame count 1..255, reset 1.
// - After the count is spent, sequencing moves to the entry's next-entry number.
module srps_store
   import srps_pkg::*;
#(
   parameter int ENTRIES = 128,
   parameter int MROI_ENTRIES = 4,
   parameter logic [31:0] EXP_MIN = 32'h0000_000F,
   parameter bit MONO = 1'b1
)(
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic FRAME_START,
   output logic SEQ_ACTIVE,
   output logic [7:0] CUR_INDEX,
   output logic [10:0] OUT_OFFSET_Y,
   output logic [1:0] OUT_H_BIN,
   output logic [1:0] OUT_V_BIN,
   output logic [22:0] OUT_EXPOSURE,
   output logic [10:0] OUT_GAIN,
   output logic [16:0] OUT_GAIN_RED,
   output logic [16:0] OUT_GAIN_BLUE,
   output logic [8:0] OUT_BLACK,
   output logic OUT_LUT_APPLY,
   output logic OUT_LUT_TABLE,
   output logic [10:0] MROI_WIDTH,
   output logic [10:0] MROI_HEIGHT,
   output logic [10:0] MROI_OFFX,
   output logic [10:0] MROI_OFFY
);

   // Range check on the signed view of the write data
   function automatic logic srps_ok(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
      return ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
   endfunction : srps_ok

   // One-based number to zero-based index
   function automatic logic [6:0] srps_idx(input logic [31:0] v);
      return 7'(v - 32'h0000_0001);
   endfunction : srps_idx

   logic ack_q;
   logic wr;
   logic [31:0] wd;
   logic [31:0] rd_d;
   logic [31:0] rd_q;
   srps_mode_t mode_q;
   srps_lut_t lut_mode_q;
   logic [6:0] sel_q;
   logic [6:0] cmd_q;
   logic [1:0] msel_q;
   logic h_en_q;
   logic v_en_q;
   logic idx_rst;
   logic [6:0] pend_q;
   logic [6:0] act_q;
   logic [7:0] used_q;

   // Per-entry storage
   logic [10:0] offy_q [ENTRIES];
   logic hbin_q [ENTRIES];
   logic vbin_q [ENTRIES];
   logic [22:0] exp_q [ENTRIES];
   logic [10:0] gain_q [ENTRIES];
   logic [16:0] red_q [ENTRIES];
   logic [16:0] blue_q [ENTRIES];
   logic [8:0] black_q [ENTRIES];
   logic lut_q [ENTRIES];
   logic [7:0] fcnt_q [ENTRIES];
   logic [6:0] next_q [ENTRIES];

   // Multi-region table
   logic [10:0] mw_q [MROI_ENTRIES];
   logic [10:0] mh_q [MROI_ENTRIES];
   logic [10:0] mx_q [MROI_ENTRIES];
   logic [10:0] my_q [MROI_ENTRIES];

   // Every access waits one cycle; it completes when waitrequest is low
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
   assign wr = AVS_WRITE & ack_q;
   assign wd = AVS_WRITEDATA;
   assign idx_rst = wr && (AVS_ADDRESS == `SRPS_OFF_IDX_RESET);
   assign AVS_READDATA = rd_q;

   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
         ack_q <= 1'b0;
      else
         ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
   end

   // Read data captured in the wait cycle, stands at the completing edge
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
         rd_q <= 32'h0000_0000;
      else if (AVS_READ && !ack_q)
         rd_q <= rd_d;
   end

   // Global settings
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         mode_q <= SRPS_NORMAL;
         lut_mode_q <= SRPS_GAMMA;
         sel_q <= 7'h00;
         msel_q <= 2'h0;
         h_en_q <= 1'b0;
         v_en_q <= 1'b0;
      end
      else if (wr)
      begin
         unique case (AVS_ADDRESS)
            `SRPS_OFF_MODE:
               if (srps_ok(wd, `SRPS_ZERO, 32'(SRPS_HOST_SEL)))
                  mode_q <= srps_mode_t'(wd[1:0]);
            `SRPS_OFF_LUT_MODE:
               if (srps_ok(wd, `SRPS_ZERO, 32'(SRPS_TABLE)))
                  lut_mode_q <= srps_lut_t'(wd[0]);
            `SRPS_OFF_ENTRY_SEL:
               if (srps_ok(wd, `SRPS_IDX_MIN, `SRPS_IDX_MAX))
                  sel_q <= srps_idx(wd);
            `SRPS_OFF_MROI_SEL:
               if (srps_ok(wd, `SRPS_IDX_MIN, `SRPS_MROI_MAX))
                  msel_q <= 2'(srps_idx(wd));
            `SRPS_OFF_H_EN:
               h_en_q <= wd[0];
            `SRPS_OFF_V_EN:
               v_en_q <= wd[0];
            default:
               ;
         endcase
      end
   end

   // Commanded entry for host-selected sequencing; index reset returns it to 1
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
         cmd_q <= 7'h00;
      else if (idx_rst)
         cmd_q <= 7'h00;
      else if (wr && AVS_ADDRESS == `SRPS_OFF_CMD_IDX && srps_ok(wd, `SRPS_IDX_MIN, `SRPS_IDX_MAX))
         cmd_q <= srps_idx(wd);
   end

   // Per-entry sequence parameters, addressed by the entry selector
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         for (int i = 0; i < ENTRIES; i++)
         begin
            offy_q[i] <= 11'h000;
            hbin_q[i] <= 1'b0;
            vbin_q[i] <= 1'b0;
            exp_q[i] <= `SRPS_EXP_RST;
            gain_q[i] <= `SRPS_GAIN_RST;
            red_q[i] <= `SRPS_CGAIN_RST;
            blue_q[i] <= `SRPS_CGAIN_RST;
            black_q[i] <= 9'h000;
            lut_q[i] <= 1'b0;
            fcnt_q[i] <= `SRPS_FCNT_RST;
            next_q[i] <= 7'h00;
         end
      end
      else if (wr)
      begin
         unique case (AVS_ADDRESS)
            `SRPS_OFF_OFFSET_Y:
               if (srps_ok(wd, `SRPS_ZERO, `SRPS_OFFY_MAX))
                  offy_q[sel_q] <= wd[10:0];
            `SRPS_OFF_H_BIN:
               if (srps_ok(wd, `SRPS_IDX_MIN, `SRPS_BIN_MAX))
                  hbin_q[sel_q] <= wd[1];
            `SRPS_OFF_V_BIN:
               if (srps_ok(wd, `SRPS_IDX_MIN, `SRPS_BIN_MAX))
                  vbin_q[sel_q] <= wd[1];
            `SRPS_OFF_EXPOSURE:
               if (srps_ok(wd, EXP_MIN, `SRPS_EXP_MAX))
                  exp_q[sel_q] <= wd[22:0];
            `SRPS_OFF_GAIN:
               if (srps_ok(wd, `SRPS_GAIN_MIN, `SRPS_GAIN_MAX))
                  gain_q[sel_q] <= wd[10:0];
            `SRPS_OFF_GAIN_RED:
               if (srps_ok(wd, `SRPS_CGAIN_MIN, `SRPS_CGAIN_MAX))
                  red_q[sel_q] <= wd[16:0];
            `SRPS_OFF_GAIN_BLUE:
               if (srps_ok(wd, `SRPS_CGAIN_MIN, `SRPS_CGAIN_MAX))
                  blue_q[sel_q] <= wd[16:0];
            `SRPS_OFF_BLACK:
               if (srps_ok(wd, `SRPS_BLACK_MIN, `SRPS_BLACK_MAX))
                  black_q[sel_q] <= wd[8:0];
            `SRPS_OFF_LUT_EN:
               lut_q[sel_q] <= wd[0];
            `SRPS_OFF_FRAME_CNT:
               if (srps_ok(wd, `SRPS_IDX_MIN, `SRPS_FCNT_MAX))
                  fcnt_q[sel_q] <= wd[7:0];
            `SRPS_OFF_NEXT_IDX:
               if (srps_ok(wd, `SRPS_IDX_MIN, `SRPS_IDX_MAX))
                  next_q[sel_q] <= srps_idx(wd);
            default:
               ;
         endcase
      end
   end

   // Multi-region table, addressed by its own selector
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         for (int i = 0; i < MROI_ENTRIES; i++)
         begin
            mw_q[i] <= `SRPS_WIDTH_RST;
            mh_q[i] <= `SRPS_HEIGHT_RST;
            mx_q[i] <= 11'h000;
            my_q[i] <= 11'h000;
         end
      end
      else if (wr)
      begin
         unique case (AVS_ADDRESS)
            `SRPS_OFF_MROI_WIDTH:
               if (srps_ok(wd, `SRPS_WIDTH_MIN, `SRPS_WIDTH_MAX))
                  mw_q[msel_q] <= wd[10:0];
            `SRPS_OFF_MROI_HEIGHT:
               if (srps_ok(wd, `SRPS_HEIGHT_MIN, `SRPS_HEIGHT_MAX))
                  mh_q[msel_q] <= wd[10:0];
            `SRPS_OFF_MROI_OFFX:
               if (srps_ok(wd, `SRPS_ZERO, `SRPS_OFFX_MAX))
                  mx_q[msel_q] <= wd[10:0];
            `SRPS_OFF_MROI_OFFY:
               if (srps_ok(wd, `SRPS_ZERO, `SRPS_OFFY_MAX))
                  my_q[msel_q] <= wd[10:0];
            default:
               ;
         endcase
      end
   end

   // Entry sequencing; the pending entry is the one the next frame will use
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         pend_q <= 7'h00;
         used_q <= 8'h00;
      end
      else if (idx_rst || (wr && AVS_ADDRESS == `SRPS_OFF_MODE))
      begin
         pend_q <= 7'h00;
         used_q <= 8'h00;
      end
      else if (mode_q == SRPS_HOST_SEL)
      begin
         pend_q <= cmd_q;
         used_q <= 8'h00;
      end
      else if (mode_q == SRPS_FRAME_COUNT && FRAME_START)
      begin
         if (used_q + 8'h01 >= fcnt_q[pend_q])
         begin
            pend_q <= next_q[pend_q];
            used_q <= 8'h00;
         end
         else
            used_q <= used_q + 8'h01;
      end
   end

   // Active entry and its settings are latched only at the frame boundary
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         act_q <= 7'h00;
         SEQ_ACTIVE <= 1'b0;
         OUT_OFFSET_Y <= 11'h000;
         OUT_H_BIN <= 2'h1;
         OUT_V_BIN <= 2'h1;
         OUT_EXPOSURE <= `SRPS_EXP_RST;
         OUT_GAIN <= `SRPS_GAIN_RST;
         OUT_GAIN_RED <= `SRPS_CGAIN_RST;
         OUT_GAIN_BLUE <= `SRPS_CGAIN_RST;
         OUT_BLACK <= 9'h000;
         OUT_LUT_APPLY <= 1'b0;
         OUT_LUT_TABLE <= 1'b0;
      end
      else if (FRAME_START)
      begin
         act_q <= pend_q;
         SEQ_ACTIVE <= (mode_q != SRPS_NORMAL);
         OUT_OFFSET_Y <= offy_q[pend_q];
         OUT_H_BIN <= (MONO && hbin_q[pend_q]) ? 2'h2 : 2'h1;
         OUT_V_BIN <= (MONO && vbin_q[pend_q]) ? 2'h2 : 2'h1;
         OUT_EXPOSURE <= exp_q[pend_q];
         OUT_GAIN <= gain_q[pend_q];
         OUT_GAIN_RED <= red_q[pend_q];
         OUT_GAIN_BLUE <= blue_q[pend_q];
         OUT_BLACK <= black_q[pend_q];
         OUT_LUT_APPLY <= lut_q[pend_q];
         OUT_LUT_TABLE <= lut_q[pend_q] && (lut_mode_q == SRPS_TABLE);
      end
   end

   // Multi-region geometry; disabled axes fall back to full frame
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         MROI_WIDTH <= `SRPS_WIDTH_RST;
         MROI_HEIGHT <= `SRPS_HEIGHT_RST;
         MROI_OFFX <= 11'h000;
         MROI_OFFY <= 11'h000;
      end
      else if (FRAME_START)
      begin
         MROI_WIDTH <= h_en_q ? mw_q[msel_q] : `SRPS_WIDTH_RST;
         MROI_OFFX <= h_en_q ? mx_q[msel_q] : 11'h000;
         MROI_HEIGHT <= v_en_q ? mh_q[msel_q] : `SRPS_HEIGHT_RST;
         MROI_OFFY <= v_en_q ? my_q[msel_q] : 11'h000;
      end
   end

   assign CUR_INDEX = {1'b0, act_q} + 8'h01;

   // Read multiplexer; signed fields read sign-extended, unmapped reads zero
   always_comb
   begin
      rd_d = 32'h0000_0000;
      unique case (AVS_ADDRESS)
         `SRPS_OFF_MODE: rd_d = {30'h0000_0000, mode_q};
         `SRPS_OFF_ENTRY_SEL: rd_d = {25'h000_0000, sel_q} + 32'h0000_0001;
         `SRPS_OFF_FRAME_CNT: rd_d = {24'h00_0000, fcnt_q[sel_q]};
         `SRPS_OFF_NEXT_IDX: rd_d = {25'h000_0000, next_q[sel_q]} + 32'h0000_0001;
         `SRPS_OFF_OFFSET_Y: rd_d = {21'h00_0000, offy_q[sel_q]};
         `SRPS_OFF_H_BIN: rd_d = hbin_q[sel_q] ? `SRPS_BIN_MAX : `SRPS_IDX_MIN;
         `SRPS_OFF_V_BIN: rd_d = vbin_q[sel_q] ? `SRPS_BIN_MAX : `SRPS_IDX_MIN;
         `SRPS_OFF_EXPOSURE: rd_d = {9'h000, exp_q[sel_q]};
         `SRPS_OFF_GAIN: rd_d = {21'h00_0000, gain_q[sel_q]};
         `SRPS_OFF_GAIN_RED: rd_d = 32'($signed(red_q[sel_q]));
         `SRPS_OFF_GAIN_BLUE: rd_d = 32'($signed(blue_q[sel_q]));
         `SRPS_OFF_BLACK: rd_d = 32'($signed(black_q[sel_q]));
         `SRPS_OFF_LUT_EN: rd_d = {31'h0000_0000, lut_q[sel_q]};
         `SRPS_OFF_LUT_MODE: rd_d = {31'h0000_0000, lut_mode_q};
         `SRPS_OFF_CMD_IDX: rd_d = {25'h000_0000, cmd_q} + 32'h0000_0001;
         `SRPS_OFF_CUR_IDX: rd_d = {24'h00_0000, CUR_INDEX};
         `SRPS_OFF_MROI_SEL: rd_d = {30'h0000_0000, msel_q} + 32'h0000_0001;
         `SRPS_OFF_MROI_WIDTH: rd_d = {21'h00_0000, mw_q[msel_q]};
         `SRPS_OFF_MROI_HEIGHT: rd_d = {21'h00_0000, mh_q[msel_q]};
         `SRPS_OFF_MROI_OFFX: rd_d = {21'h00_0000, mx_q[msel_q]};
         `SRPS_OFF_MROI_OFFY: rd_d = {21'h00_0000, my_q[msel_q]};
         `SRPS_OFF_H_EN: rd_d = {31'h0000_0000, h_en_q};
         `SRPS_OFF_V_EN: rd_d = {31'h0000_0000, v_en_q};
         default: rd_d = 32'h0000_0000;
      endcase
   end

endmodule : srps_store
`default_nettype wire

// File: testbench/srps_store_chk.sv
`default_nettype none
// Watches the store outputs for range and frame-boundary slips
module srps_store_chk #(
   parameter logic [31:0] EXP_MIN = 32'h0000_000F
)(
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic FRAME_START,
   input wire logic [7:0] CUR_INDEX,
   input wire logic [10:0] OUT_OFFSET_Y,
   input wire logic [1:0] OUT_H_BIN,
   input wire logic [1:0] OUT_V_BIN,
   input wire logic [22:0] OUT_EXPOSURE,
   input wire logic [10:0] OUT_GAIN,
   input wire logic OUT_LUT_APPLY,
   input wire logic OUT_LUT_TABLE,
   input wire logic [10:0] MROI_WIDTH,
   input wire logic [10:0] MROI_HEIGHT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RESETN);

   // Entry number, gain, exposure and region width may not move between frame pulses
   hold_frame_a: assert property (!FRAME_START |=> $stable(CUR_INDEX) && $stable(OUT_GAIN)
      && $stable(OUT_EXPOSURE) && $stable(MROI_WIDTH)) else $error("output moved between frames");
   // Latched values stay inside their accepted ranges
   idx_range_a: assert property (CUR_INDEX >= 8'h1 && CUR_INDEX <= 8'h80)
      else $error("entry number out of range");
   gain_range_a: assert property (OUT_GAIN >= 11'h64 && OUT_GAIN <= 11'h640)
      else $error("gain out of range");
   exp_range_a: assert property ({9'h0, OUT_EXPOSURE} >= EXP_MIN && OUT_EXPOSURE <= 23'h7A_1200)
      else $error("exposure out of range");
   offy_range_a: assert property (OUT_OFFSET_Y <= 11'h4BE)
      else $error("vertical offset out of range");
   bin_value_a: assert property (OUT_H_BIN inside {2'h1, 2'h2} && OUT_V_BIN inside {2'h1, 2'h2})
      else $error("binning factor out of range");
   mroi_size_a: assert property (MROI_WIDTH >= 11'h60 && MROI_WIDTH <= 11'h790
      && MROI_HEIGHT >= 11'h2 && MROI_HEIGHT <= 11'h4C0) else $error("region size out of range");
   // Table mapping only ever for an entry with mapping enabled
   lut_table_a: assert property (OUT_LUT_TABLE |-> OUT_LUT_APPLY)
      else $error("table mapping without enable");
endmodule : srps_store_chk

bind srps_store srps_store_chk #(.EXP_MIN(EXP_MIN)) u_chk (
   .SYS_CLK(SYS_CLK), .RESETN(RESETN), .FRAME_START(FRAME_START), .CUR_INDEX(CUR_INDEX),
   .OUT_OFFSET_Y(OUT_OFFSET_Y), .OUT_H_BIN(OUT_H_BIN), .OUT_V_BIN(OUT_V_BIN), .OUT_EXPOSURE(OUT_EXPOSURE),
   .OUT_GAIN(OUT_GAIN), .OUT_LUT_APPLY(OUT_LUT_APPLY), .OUT_LUT_TABLE(OUT_LUT_TABLE),
   .MROI_WIDTH(MROI_WIDTH), .MROI_HEIGHT(MROI_HEIGHT)
);
`default_nettype wire

// File: testbench/srps_store_tb.sv
`default_nettype none
module srps_store_tb
   import srps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic SYS_CLK = 1'b0;
   logic RESETN = 1'b0;
   logic [7:0] AVS_ADDRESS = 8'h0;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic FRAME_START = 1'b0;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST, SEQ_ACTIVE, OUT_LUT_APPLY, OUT_LUT_TABLE;
   logic [7:0] CUR_INDEX;
   logic [1:0] OUT_H_BIN, OUT_V_BIN;
   logic [22:0] OUT_EXPOSURE;
   logic [16:0] OUT_GAIN_RED, OUT_GAIN_BLUE;
   logic [8:0] OUT_BLACK;
   logic [10:0] OUT_OFFSET_Y, OUT_GAIN, MROI_WIDTH, MROI_HEIGHT, MROI_OFFX, MROI_OFFY;
   int n_fail = 0;
   int compares = 0;
   logic [31:0] seed = 32'h1971_c638;
   logic [31:0] rq[$];
   logic [43:0] fq[$];
   logic [57:0] xq[$];
   logic le = 1'b0;
   logic [8:0] eb = 9'h000;
   logic [1:0] eh = 2'h1;
   logic [10:0] ey = 11'h000;
   logic fs_q = 1'b0;
   logic lm = 1'b0;
   logic [10:0] ew = 11'h790;
   logic [10:0] eo = 11'h0;
   logic [10:0] g1, g3, w;
   // Reset readback table, unmapped address last
   logic [7:0] ra[23] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30,
      8'h34, 8'h38, 8'h3C, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h60};
   logic [15:0] rv[23] = '{16'h0, 16'h1, 16'h1, 16'h0, 16'h1, 16'h1, 16'h1F40, 16'h64, 16'h93F4, 16'h93F4,
      16'h0, 16'h0, 16'h0, 16'h1, 16'h1, 16'h1, 16'h790, 16'h4C0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
   // Accepted range ends; selectors last so per-entry writes hit entry 1
   logic [7:0] ta[15] = '{8'h10, 8'h14, 8'h1C, 8'h20, 8'h24, 8'h2C, 8'h08, 8'h0C, 8'h48, 8'h4C, 8'h50,
      8'h44, 8'h04, 8'h38, 8'h00};
   logic [31:0] tl[15] = '{32'h0, 32'h1, 32'hF, 32'h64, 32'hFFFF_EE4B, 32'hFFFF_FF7B, 32'h1, 32'h1,
      32'h60, 32'h2, 32'h0, 32'h1, 32'h1, 32'h1, 32'h0};
   logic [31:0] th[15] = '{32'h4BE, 32'h2, 32'h7A_1200, 32'h640, 32'h93F4, 32'hFF, 32'hFF, 32'h80,
      32'h790, 32'h4C0, 32'h730, 32'h4, 32'h80, 32'h80, 32'h2};

   srps_store DUT (
      .SYS_CLK(SYS_CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .FRAME_START(FRAME_START), .SEQ_ACTIVE(SEQ_ACTIVE),
      .CUR_INDEX(CUR_INDEX), .OUT_OFFSET_Y(OUT_OFFSET_Y), .OUT_H_BIN(OUT_H_BIN), .OUT_V_BIN(OUT_V_BIN),
      .OUT_EXPOSURE(OUT_EXPOSURE), .OUT_GAIN(OUT_GAIN), .OUT_GAIN_RED(OUT_GAIN_RED),
      .OUT_GAIN_BLUE(OUT_GAIN_BLUE), .OUT_BLACK(OUT_BLACK), .OUT_LUT_APPLY(OUT_LUT_APPLY),
      .OUT_LUT_TABLE(OUT_LUT_TABLE), .MROI_WIDTH(MROI_WIDTH), .MROI_HEIGHT(MROI_HEIGHT),
      .MROI_OFFX(MROI_OFFX), .MROI_OFFY(MROI_OFFY)
   );

   // 40 MHz system clock
   always #12.5 SYS_CLK = ~SYS_CLK;

   // Counts every comparison and reports a mismatch at once
   task automatic chk(input [63:0] got, input [63:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // One bus transfer, held until waitrequest is seen low at an edge
   task automatic bus(input wr, input [7:0] a, input [31:0] d);
      int n;
      n = 0;
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      do
      begin
         @(posedge SYS_CLK);
         n++;
      end
      while (AVS_WAITREQUEST !== 1'b0 && n < 64);
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      if (n >= 64)
      begin
         n_fail++;
         end_sim();
      end
      @(posedge SYS_CLK);
   endtask : bus

   task automatic rd(input [7:0] a, input [31:0] e);
      rq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd

   task automatic wr(input [7:0] a, input [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   // Frame pulse; notes what entry 1 or entry 3 should latch
   task automatic fe(input sa, input [7:0] ix);
      if (ix == 8'h1)
      begin
         fq.push_back({sa, ix, g1, le, le & lm, ew, eo});
         xq.push_back({eb, 17'h0_93F4, 17'h0_93F4, ey, eh, 2'h1});
      end
      else
      begin
         fq.push_back({sa, ix, g3, 1'b0, 1'b0, ew, eo});
         xq.push_back({9'h000, 17'h1_EE4B, 17'h0_93F4, ey, 2'h1, 2'h1});
      end
      FRAME_START <= 1'b1;
      @(posedge SYS_CLK);
      FRAME_START <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
   endtask : fe

   // Watcher: takes the oldest note whenever read data or a new frame shows
   always @(posedge SYS_CLK)
   begin
      if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0)
         chk(64'(AVS_READDATA), 64'(rq.pop_front()));
      if (fs_q)
      begin
         chk(64'({SEQ_ACTIVE, CUR_INDEX, OUT_GAIN, OUT_LUT_APPLY, OUT_LUT_TABLE, MROI_WIDTH, MROI_OFFX}),
            64'(fq.pop_front()));
         chk(64'({OUT_BLACK, OUT_GAIN_RED, OUT_GAIN_BLUE, MROI_OFFY, OUT_H_BIN, OUT_V_BIN}),
            64'(xq.pop_front()));
      end
      fs_q <= FRAME_START;
   end

   // Main sequence
   initial
   begin
      repeat (12) @(posedge SYS_CLK);
      RESETN <= 1'b1;
      @(posedge SYS_CLK);
      // Defaults, after an unmapped write and a write to the read-only index
      wr(8'h60, 32'h7);
      wr(8'h3C, 32'h5);
      for (int i = 0; i < 23; i++)
         rd(ra[i], {16'h0, rv[i]});
      g1 = 11'h64;
      fe(1'b0, 8'h1);
      // Both range ends stick, one past either end is dropped
      for (int i = 0; i < 15; i++)
      begin
         wr(ta[i], tl[i]);
         rd(ta[i], tl[i]);
         wr(ta[i], th[i]);
         wr(ta[i], th[i] + 32'h1);
         wr(ta[i], tl[i] - 32'h1);
         rd(ta[i], th[i]);
      end
      // Entry 1: two frames then entry 3; entry 3: one frame then entry 1
      g1 = 11'(32'h64 + rnd() % 32'h5DD);
      eb = 9'h0FF;
      eh = 2'h2;
      g3 = 11'(32'h64 + rnd() % 32'h5DD);
      w = 11'(32'h60 + rnd() % 32'h731);
      wr(8'h04, 32'h1);
      wr(8'h08, 32'h2);
      wr(8'h0C, 32'h3);
      wr(8'h20, 32'(g1));
      wr(8'h30, 32'h1);
      le = 1'b1;
      wr(8'h04, 32'h3);
      wr(8'h08, 32'h1);
      wr(8'h0C, 32'h1);
      wr(8'h20, 32'(g3));
      wr(8'h24, 32'hFFFF_EE4B);
      wr(8'h34, 32'h1);
      lm = 1'b1;
      wr(8'h44, 32'h2);
      wr(8'h48, 32'(w));
      wr(8'h50, 32'h8);
      wr(8'h54, 32'h10);
      wr(8'h00, 32'h1);
      fe(1'b1, 8'h1);
      fe(1'b1, 8'h1);
      // Entry 3 is pending here; the reset sends it back to entry 1
      wr(8'h40, rnd());
      fe(1'b1, 8'h1);
      fe(1'b1, 8'h1);
      fe(1'b1, 8'h3);
      fe(1'b1, 8'h1);
      rd(8'h3C, 32'h1);
      // Host-selected entry, then index reset and gamma mapping
      wr(8'h00, 32'h2);
      wr(8'h38, 32'h3);
      fe(1'b1, 8'h3);
      rd(8'h3C, 32'h3);
      wr(8'h38, 32'h1);
      fe(1'b1, 8'h1);
      wr(8'h38, 32'h3);
      wr(8'h40, 32'h0);
      wr(8'h34, 32'h0);
      lm = 1'b0;
      fe(1'b1, 8'h1);
      rd(8'h38, 32'h1);
      // Normal output; horizontal enable on the second and first region
      wr(8'h00, 32'h0);
      wr(8'h58, 32'h1);
      wr(8'h5C, 32'h1);
      ew = w;
      eo = 11'h8;
      ey = 11'h010;
      fe(1'b0, 8'h1);
      wr(8'h44, 32'h1);
      ew = 11'h790;
      eo = 11'h730;
      ey = 11'h000;
      fe(1'b0, 8'h1);
      wr(8'h58, 32'h0);
      eo = 11'h0;
      fe(1'b0, 8'h1);
      end_sim();
   end
endmodule : srps_store_tb
`default_nettype wire
